// ===== lpd_bank_regs.vh
`ifndef LPD_BANK_REGS_VH
`define LPD_BANK_REGS_VH

// Mode register addresses.
`define LPD_MR_BURST 8'h01
`define LPD_MR_LATENCY 8'h02
`define LPD_MR_RESET 8'h3f

// Mode register fields and reset values.
`define LPD_BL_RST 3'h2
`define LPD_BL4 3'h2
`define LPD_BL8 3'h3
`define LPD_BL16 3'h4
`define LPD_RLWL_RST 4'h1
`define LPD_RLWL_MIN 4'h1
`define LPD_RLWL_MAX 4'h6

// Command bus field positions (rising half).
`define LPD_CA_ACT_BANK_LSB 4
`define LPD_CA_COL_BANK_LSB 7
`define LPD_CA_ALL_BANKS 4
`define LPD_CA_READ 2

// Core word layout: bank, row, column.
`define LPD_ADDR_W 26
`define LPD_ROW_W 14
`define LPD_COL_W 9
`define LPD_BANK_LSB 23
`define LPD_ROW_LSB 9
`define LPD_DATA_W 32
`define LPD_WORD_W 58

// Latency pipeline depth covers the largest read latency.
`define LPD_PIPE_LEN 9
`define LPD_PIPE_TOP 8

`endif

// ===== lpd_pair_buf.v
`timescale 1ns/1ns
`default_nettype none
`include "lpd_bank_regs.vh"

module lpd_pair_buf (
   input wire clk,
   input wire rst,
   input wire inValid,
   output wire inReady,
   input wire [`LPD_WORD_W-1:0] inData,
   output reg outValid,
   input wire outReady,
   output reg [`LPD_WORD_W-1:0] outData
);

   reg tailValid_reg;
   reg [`LPD_WORD_W-1:0] tailData_reg;
   wire headFree;

   // Accepting only while the tail is empty keeps the ready path a flop.
   assign inReady = ~tailValid_reg;
   assign headFree = ~outValid | outReady;

   always @(posedge clk)
   begin
      if (rst)
      begin
         outValid <= 1'b0;
         outData <= {`LPD_WORD_W{1'b0}};
         tailValid_reg <= 1'b0;
         tailData_reg <= {`LPD_WORD_W{1'b0}};
      end
      else if (headFree)
      begin
         if (tailValid_reg)
         begin
            outData <= tailData_reg;
            outValid <= 1'b1;
            tailValid_reg <= 1'b0;
         end
         else
         begin
            outData <= inData;
            outValid <= inValid;
         end
      end
      else if (inValid && !tailValid_reg)
      begin
         tailData_reg <= inData;
         tailValid_reg <= 1'b1;
      end
   end

endmodule
`default_nettype wire

// ===== lpd_bank_access.v
// Function
// - CS low, CA0 low, CA1 high: activate.
// - Activate opens given row in addressed bank.
// - CS low, CA0 high, CA1 low: column access.
// - Start column from CA5r-CA6r and CA1f-CA6f.
// - Read data starts RL clocks after command.
// - Strobe preamble low, data edge-aligned with strobe.
// - Reads every BL/2 clocks run seamless.
// - Device captures write beats on strobe edges.
// - Mode address 3F only triggers reset.
`timescale 1ns/1ns
`default_nettype none
`include "lpd_bank_regs.vh"

module lpd_bank_access (
   input wire ref_clk,
   input wire rst,
   input wire ckIn,
   input wire csN,
   input wire [9:0] caIn,
   input wire [31:0] dqIn,
   output reg [31:0] dqOut,
   output reg dqOe,
   input wire [3:0] dqsIn,
   output reg [3:0] dqsOut,
   output reg [3:0] dqsOe,
   output wire coreWrValid,
   input wire coreWrReady,
   output wire [`LPD_WORD_W-1:0] coreWrWord,
   output reg [`LPD_ADDR_W-1:0] coreRdAddr,
   input wire [31:0] coreRdData,
   output reg modeResetPulse,
   output reg accessError,
   output reg beatDropped,
   output reg [7:0] bankOpen
);

   // Burst length in beats from the burst code.
   function [4:0] blBeats;
      input [2:0] code;
      begin
         if (code == `LPD_BL16)
            blBeats = 5'h10;
         else if (code == `LPD_BL8)
            blBeats = 5'h08;
         else
            blBeats = 5'h04;
      end
   endfunction

   // Sequential wrap inside the burst-sized column block.
   function [8:0] burstCol;
      input [8:0] col;
      input [4:0] beat;
      input [2:0] code;
      reg [8:0] mask;
      begin
         mask = {4'h0, blBeats(code) - 5'h01};
         burstCol = (col & ~mask) | ((col + {4'h0, beat}) & mask);
      end
   endfunction

   function [3:0] wlOf;
      input [3:0] code;
      begin
         if (code == 4'h1)
            wlOf = 4'h1;
         else if (code == 4'h2 || code == 4'h3)
            wlOf = 4'h2;
         else if (code == 4'h4)
            wlOf = 4'h3;
         else
            wlOf = 4'h4;
      end
   endfunction

   // Two-flop synchronisers; the link clock is sampled like data.
   reg ckS1, ckS2, ckS3;
   reg csS1, csS2;
   reg [9:0] caS1, caS2;
   reg [31:0] dqS1, dqS2;
   reg dqsS1, dqsS2, dqsS3;

   always @(posedge ref_clk)
   begin
      if (rst)
      begin
         ckS1 <= 1'b0;
         ckS2 <= 1'b0;
         ckS3 <= 1'b0;
         csS1 <= 1'b1;
         csS2 <= 1'b1;
         caS1 <= 10'h000;
         caS2 <= 10'h000;
         dqS1 <= 32'h00000000;
         dqS2 <= 32'h00000000;
         dqsS1 <= 1'b0;
         dqsS2 <= 1'b0;
         dqsS3 <= 1'b0;
      end
      else
      begin
         ckS1 <= ckIn;
         ckS2 <= ckS1;
         ckS3 <= ckS2;
         csS1 <= csN;
         csS2 <= csS1;
         caS1 <= caIn;
         caS2 <= caS1;
         dqS1 <= dqIn;
         dqS2 <= dqS1;
         dqsS1 <= dqsIn[0];
         dqsS2 <= dqsS1;
         dqsS3 <= dqsS2;
      end
   end

   wire ckRise = ckS2 & ~ckS3;
   wire ckFall = ~ckS2 & ckS3;
   wire dqsEdge = dqsS2 ^ dqsS3;

   reg [9:0] caRise_reg;
   reg csLow_reg;
   reg [2:0] blCode_reg;
   reg [3:0] latCode_reg;
   reg [`LPD_ROW_W-1:0] openRow [0:7];
   reg [`LPD_PIPE_TOP:0] pipeV;
   reg [`LPD_PIPE_TOP:0] pipeWr;
   reg [`LPD_ADDR_W-1:0] pipeAddr [0:`LPD_PIPE_TOP];
   reg rdActive;
   reg [`LPD_ADDR_W-1:0] rdBase;
   reg [4:0] rdBeat, rdLeft;
   reg wrActive;
   reg [`LPD_ADDR_W-1:0] wrBase;
   reg [4:0] wrBeat, wrLeft;
   reg pushValid;
   reg [`LPD_WORD_W-1:0] pushWord;
   wire pushReady;
   integer i;

   // A command is complete once its falling half has been sampled.
   wire cmdStrobe = ckFall & csLow_reg;
   wire [9:0] caR = caRise_reg;
   wire [9:0] caF = caS2;
   wire isAct = ~caR[0] & caR[1];
   wire isCol = caR[0] & ~caR[1];
   wire isRead = isCol & caR[`LPD_CA_READ];
   wire isPre = caR[0] & caR[1] & ~caR[2] & caR[3];
   wire isMrw = (caR[3:0] == 4'h0);
   wire [2:0] actBank = caR[`LPD_CA_ACT_BANK_LSB+2:`LPD_CA_ACT_BANK_LSB];
   wire [2:0] colBank = caR[`LPD_CA_COL_BANK_LSB+2:`LPD_CA_COL_BANK_LSB];
   wire [`LPD_ROW_W-1:0] actRow = {caR[2], caF, caR[9:7]};
   wire [8:0] startCol = {caF[6:1], caR[6:5], 1'b0};
   wire [7:0] mrAddr = {caF[1:0], caR[9:4]};
   wire [7:0] mrData = caF[9:2];
   wire [3:0] readLat = latCode_reg + 4'h2;
   wire [3:0] cmdLat = isRead ? readLat : wlOf(latCode_reg);
   wire [4:0] bl = blBeats(blCode_reg);

   wire startRd = ckRise & pipeV[1] & ~pipeWr[1];
   wire startWr = ckRise & pipeV[1] & pipeWr[1];
   wire preambleDue = ckRise ? (pipeV[2] & ~pipeWr[2])
                             : (pipeV[1] & ~pipeWr[1]);
   wire [`LPD_ADDR_W-1:0] curWrBase = startWr ? pipeAddr[1] : wrBase;
   wire [4:0] curWrBeat = startWr ? 5'h00 : wrBeat;
   wire [4:0] curWrLeft = startWr ? bl : wrLeft;
   wire takeBeat = dqsEdge & (wrActive | startWr);

   // Command decode, bank state, mode registers and latency pipeline.
   always @(posedge ref_clk)
   begin
      if (rst)
      begin
         caRise_reg <= 10'h000;
         csLow_reg <= 1'b0;
         blCode_reg <= `LPD_BL_RST;
         latCode_reg <= `LPD_RLWL_RST;
         bankOpen <= 8'h00;
         accessError <= 1'b0;
         modeResetPulse <= 1'b0;
         pipeV <= {`LPD_PIPE_LEN{1'b0}};
         pipeWr <= {`LPD_PIPE_LEN{1'b0}};
         for (i = 0; i < 8; i = i + 1)
            openRow[i] <= {`LPD_ROW_W{1'b0}};
         for (i = 0; i < `LPD_PIPE_LEN; i = i + 1)
            pipeAddr[i] <= {`LPD_ADDR_W{1'b0}};
      end
      else
      begin
         modeResetPulse <= 1'b0;
         if (ckRise)
         begin
            caRise_reg <= caS2;
            csLow_reg <= ~csS2;
            // Each link clock moves pending bursts one step closer.
            pipeV <= {1'b0, pipeV[`LPD_PIPE_TOP:1]};
            pipeWr <= {1'b0, pipeWr[`LPD_PIPE_TOP:1]};
            for (i = 0; i < `LPD_PIPE_TOP; i = i + 1)
               pipeAddr[i] <= pipeAddr[i+1];
         end
         if (cmdStrobe)
         begin
            csLow_reg <= 1'b0;
            if (isAct)
            begin
               // Reopening an open bank is flagged, yet the new row still replaces the old one.
               if (bankOpen[actBank])
                  accessError <= 1'b1;
               bankOpen[actBank] <= 1'b1;
               openRow[actBank] <= actRow;
            end
            else if (isCol)
            begin
               if (!bankOpen[colBank])
                  accessError <= 1'b1;
               pipeV[cmdLat] <= 1'b1;
               pipeWr[cmdLat] <= ~isRead;
               pipeAddr[cmdLat] <= {colBank, openRow[colBank], startCol};
            end
            else if (isPre)
            begin
               if (caR[`LPD_CA_ALL_BANKS])
                  bankOpen <= 8'h00;
               else
                  bankOpen[colBank] <= 1'b0;
            end
            else if (isMrw)
            begin
               if (mrAddr == `LPD_MR_RESET)
               begin
                  // Written data is discarded; only the event counts.
                  modeResetPulse <= 1'b1;
                  blCode_reg <= `LPD_BL_RST;
                  latCode_reg <= `LPD_RLWL_RST;
                  bankOpen <= 8'h00;
                  pipeV <= {`LPD_PIPE_LEN{1'b0}};
               end
               else if (mrAddr == `LPD_MR_BURST)
               begin
                  if (mrData[2:0] == `LPD_BL4 || mrData[2:0] == `LPD_BL8 ||
                      mrData[2:0] == `LPD_BL16)
                     blCode_reg <= mrData[2:0];
               end
               else if (mrAddr == `LPD_MR_LATENCY)
               begin
                  if (mrData[3:0] >= `LPD_RLWL_MIN &&
                      mrData[3:0] <= `LPD_RLWL_MAX)
                     latCode_reg <= mrData[3:0];
               end
            end
         end
      end
   end

   // Read burst engine. A newer read takes over at its own start edge.
   always @(posedge ref_clk)
   begin
      if (rst)
      begin
         rdActive <= 1'b0;
         rdBase <= {`LPD_ADDR_W{1'b0}};
         rdBeat <= 5'h00;
         rdLeft <= 5'h00;
         dqOut <= 32'h00000000;
         dqOe <= 1'b0;
         dqsOut <= 4'h0;
         dqsOe <= 4'h0;
         coreRdAddr <= {`LPD_ADDR_W{1'b0}};
      end
      else
      begin
         // The core answers within a cycle; link edges are far apart.
         // While CK is low a pending read needs its first word next.
         if (rdActive && (ckS2 || !pipeV[1] || pipeWr[1]))
            coreRdAddr <= {rdBase[`LPD_ADDR_W-1:`LPD_ROW_LSB],
                           burstCol(rdBase[8:0], rdBeat, blCode_reg)};
         else
            coreRdAddr <= {pipeAddr[1][`LPD_ADDR_W-1:`LPD_ROW_LSB],
                           burstCol(pipeAddr[1][8:0], 5'h00, blCode_reg)};
         if (startRd)
         begin
            rdActive <= 1'b1;
            rdBase <= pipeAddr[1];
            rdBeat <= 5'h01;
            rdLeft <= bl - 5'h01;
            dqOut <= coreRdData;
            dqOe <= 1'b1;
            dqsOut <= 4'hf;
            dqsOe <= 4'hf;
         end
         else if (rdActive && (ckRise || ckFall))
         begin
            if (rdLeft != 5'h00)
            begin
               dqOut <= coreRdData;
               dqsOut <= {4{ckRise}};
               rdBeat <= rdBeat + 5'h01;
               rdLeft <= rdLeft - 5'h01;
            end
            else
            begin
               rdActive <= 1'b0;
               dqOe <= 1'b0;
               dqsOut <= 4'h0;
               // A read starting at the next rising edge keeps the strobe low.
               dqsOe <= {4{preambleDue}};
            end
         end
         else if (ckRise && preambleDue)
         begin
            dqsOut <= 4'h0;
            dqsOe <= 4'hf;
         end
      end
   end

   // Write capture: one word per strobe edge until the burst is in.
   always @(posedge ref_clk)
   begin
      if (rst)
      begin
         wrActive <= 1'b0;
         wrBase <= {`LPD_ADDR_W{1'b0}};
         wrBeat <= 5'h00;
         wrLeft <= 5'h00;
         pushValid <= 1'b0;
         pushWord <= {`LPD_WORD_W{1'b0}};
         beatDropped <= 1'b0;
      end
      else
      begin
         // The link cannot be stalled, so an overrun is only reported.
         if (pushValid && !pushReady)
            beatDropped <= 1'b1;
         pushValid <= takeBeat;
         if (startWr)
         begin
            wrActive <= 1'b1;
            wrBase <= pipeAddr[1];
            wrBeat <= 5'h00;
            wrLeft <= bl;
         end
         if (takeBeat)
         begin
            pushWord <= {curWrBase[`LPD_ADDR_W-1:`LPD_ROW_LSB],
                         burstCol(curWrBase[8:0], curWrBeat, blCode_reg),
                         dqS2};
            wrBeat <= curWrBeat + 5'h01;
            wrLeft <= curWrLeft - 5'h01;
            if (curWrLeft == 5'h01)
               wrActive <= 1'b0;
         end
      end
   end

   lpd_pair_buf wrBuf (
      .clk(ref_clk),
      .rst(rst),
      .inValid(pushValid),
      .inReady(pushReady),
      .inData(pushWord),
      .outValid(coreWrValid),
      .outReady(coreWrReady),
      .outData(coreWrWord)
   );

endmodule
`default_nettype wire

// ===== lpd_bank_access_asserts.sv
`timescale 1ns/1ns
`default_nettype none
`include "lpd_bank_regs.vh"
module lpd_bank_access_asserts (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic dqOe,
   input wire logic [3:0] dqsOut,
   input wire logic [3:0] dqsOe,
   input wire logic coreWrValid,
   input wire logic coreWrReady,
   input wire logic [`LPD_WORD_W-1:0] coreWrWord,
   input wire logic modeResetPulse,
   input wire logic beatDropped,
   input wire logic [7:0] bankOpen
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   // The strobe idles low for one whole link cycle before the first beat.
   sequence sPreamble;
      dqsOe == 4'hf && dqsOut == 4'h0 && !dqOe;
   endsequence
   sequence sFirstBeat;
      dqOe && dqsOut == 4'hf;
   endsequence
   a_read_preamble: assert property (
      $rose(dqsOe[0]) |-> sPreamble[*8] ##1 sFirstBeat)
      else $error("Read preamble has the wrong shape.");
   a_strobe_with_data: assert property (
      dqOe |-> dqsOe == 4'hf)
      else $error("Data driven without its strobe.");
   a_lanes_equal: assert property (
      (dqsOe == 4'h0 || dqsOe == 4'hf) && (dqsOut == 4'h0 || dqsOut == 4'hf))
      else $error("Strobe lanes disagree.");
   a_beat_cadence: assert property (
      dqOe && $changed(dqsOut) |=>
      $stable(dqsOut)[*3] ##1 (!dqOe || $changed(dqsOut)))
      else $error("Read beat does not last half a link cycle.");
   a_mode_pulse: assert property (
      modeResetPulse |=> !modeResetPulse)
      else $error("Mode reset pulse longer than one cycle.");
   a_reset_closes: assert property (
      modeResetPulse |-> ##[0:1] bankOpen == 8'h00)
      else $error("Mode reset left a bank open.");
   a_one_bank: assert property (
      $countones(bankOpen & ~$past(bankOpen)) <= 1)
      else $error("More than one bank opened at once.");
   a_word_hold: assert property (
      coreWrValid && !coreWrReady |=> coreWrValid && $stable(coreWrWord))
      else $error("Write word changed while stalled.");
   a_drop_sticky: assert property (
      beatDropped |=> beatDropped)
      else $error("Dropped beat flag cleared itself.");
endmodule
bind lpd_bank_access lpd_bank_access_asserts i_lpd_bank_access_asserts (
   .ref_clk(ref_clk), .rst(rst), .dqOe(dqOe), .dqsOut(dqsOut),
   .dqsOe(dqsOe), .coreWrValid(coreWrValid), .coreWrReady(coreWrReady),
   .coreWrWord(coreWrWord), .modeResetPulse(modeResetPulse),
   .beatDropped(beatDropped), .bankOpen(bankOpen)
);
`default_nettype wire

// ===== lpd_ctrl_model.sv
`timescale 1ns/1ns
`default_nettype none
module lpd_ctrl_model (
   input wire logic ref_clk,
   output logic ckIn,
   output logic csN,
   output logic [9:0] caIn,
   output logic [31:0] dqIn,
   output logic [3:0] dqsIn
);
   initial
   begin
      ckIn = 1'b0;
      csN = 1'b1;
      caIn = 10'h000;
      dqIn = 32'h0000_0000;
      dqsIn = 4'h0;
   end
   task automatic tick(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   // One link cycle of eight block cycles; CK rests low after it.
   task automatic cyc(input logic go, input logic [9:0] r, input logic [9:0] f);
      tick(1);
      csN = ~go;
      caIn = r;
      ckIn = 1'b1;
      tick(4);
      caIn = f;
      ckIn = 1'b0;
      tick(3);
      csN = 1'b1;
      caIn = ~f;
   endtask
   task automatic nop(input int n);
      repeat (n) cyc(1'b0, 10'h155, 10'h2aa);
   endtask
   // Strobe edges sit two block cycles apart so the synchroniser sees each.
   task automatic wr(input logic [9:0] r, input logic [9:0] f,
      input logic [31:0] d);
      cyc(1'b1, r, f);
      fork
         nop(2);
         begin
            tick(2);
            for (int k = 0; k < 4; k++)
            begin
               tick(1);
               dqIn = d + k;
               tick(1);
               dqsIn = ~dqsIn;
            end
            tick(1);
            dqIn = ~dqIn;
         end
      join
   endtask
endmodule
`default_nettype wire

// ===== lpddr2_bank_activate_burst_access_bench.sv
`timescale 1ns/1ns
`default_nettype none
`include "lpd_bank_regs.vh"
module lpddr2_bank_activate_burst_access_bench;
   logic ref_clk, rst, ckIn, csN, dqOe, coreWrValid, coreWrReady;
   logic modeResetPulse, beatDropped, pOe, accessError;
   logic [9:0] caIn;
   logic [31:0] dqIn, dqOut, coreRdData;
   logic [3:0] dqsIn, dqsOut, dqsOe, pDqs;
   logic [`LPD_WORD_W-1:0] coreWrWord;
   logic [`LPD_ADDR_W-1:0] coreRdAddr;
   logic [7:0] bankOpen;
   logic [63:0] eq[$], rq[$], wq[$];
   int errorCnt, nChecks, pulses;
   localparam int fawNs = 7500; // Arbitrary four-activate window.
   localparam int fawClk = (fawNs + 799) / 800;
   localparam int tRpabClk = 4; // Arbitrary all-bank precharge wait.
   // The core answers with a word that encodes its own address.
   assign coreRdData = {6'h15, coreRdAddr};
   lpd_ctrl_model i_lpd_ctrl_model (.ref_clk(ref_clk), .ckIn(ckIn),
      .csN(csN), .caIn(caIn), .dqIn(dqIn), .dqsIn(dqsIn));
   lpd_bank_access i_lpd_bank_access (.ref_clk(ref_clk), .rst(rst),
      .ckIn(ckIn), .csN(csN), .caIn(caIn), .dqIn(dqIn), .dqOut(dqOut),
      .dqOe(dqOe), .dqsIn(dqsIn), .dqsOut(dqsOut), .dqsOe(dqsOe),
      .coreWrValid(coreWrValid), .coreWrReady(coreWrReady),
      .coreWrWord(coreWrWord), .coreRdAddr(coreRdAddr),
      .coreRdData(coreRdData), .modeResetPulse(modeResetPulse),
      .accessError(accessError), .beatDropped(beatDropped),
      .bankOpen(bankOpen));
   initial
   begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   // A new beat shows as a strobe toggle, so seamless bursts stay apart.
   always @(posedge ref_clk)
   begin
      if (dqOe && (!pOe || dqsOut !== pDqs))
         rq.push_back(dqOut);
      if (coreWrValid && coreWrReady)
         wq.push_back(coreWrWord);
      if (modeResetPulse)
         pulses++;
      pOe <= dqOe;
      pDqs <= dqsOut;
   end
   task automatic conclude;
      $display("Checks %0d, errors %0d", nChecks, errorCnt);
      if (errorCnt == 0 && nChecks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      nChecks++;
      if (got !== exp)
      begin
         errorCnt++;
         $display("Error at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   function automatic logic [13:0] rowOf(input logic [2:0] b);
      return {1'b0, 10'h2a5 ^ {7'h0, b}, 3'h0};
   endfunction
   task automatic expBurst(input logic [2:0] b, input logic [8:0] s,
      input int bl, input logic wr, input logic [31:0] d);
      logic [8:0] c;
      for (int n = 0; n < bl; n++)
      begin
         c = (s & ~(bl - 1)) | ((s + n) & (bl - 1));
         eq.push_back(wr ? {b, rowOf(b), c, d + n} : {6'h15, b, rowOf(b), c});
      end
   endtask
   task automatic drain(input string name, input logic wr);
      while (eq.size() > 0 && (wr ? wq.size() : rq.size()) > 0)
         chk(wr ? wq.pop_front() : rq.pop_front(), eq.pop_front());
      eq.delete();
      rq.delete();
      wq.delete();
      $display("Test %s finished", name);
   endtask
   task automatic cmd(input logic [9:0] r, input logic [9:0] f);
      i_lpd_ctrl_model.cyc(1'b1, r, f);
   endtask
   task automatic mrw(input logic [7:0] ma, input logic [7:0] op);
      cmd({ma[5:0], 4'h0}, {op, ma[7:6]});
      i_lpd_ctrl_model.nop(1);
   endtask
   task automatic rd(input logic [2:0] b, input logic [8:0] c, input int bl);
      cmd({b, c[2:1], 5'b00101}, {3'h0, c[8:3], 1'b0});
      expBurst(b, c, bl, 1'b0, 32'h0);
   endtask
   task automatic wrt(input logic [2:0] b, input logic [8:0] c,
      input logic [31:0] d);
      i_lpd_ctrl_model.wr({b, c[2:1], 5'b00001}, {3'h0, c[8:3], 1'b0}, d);
      i_lpd_ctrl_model.nop(2);
      expBurst(b, c, 4, 1'b1, d);
   endtask
   initial
   begin
      #400000;
      errorCnt++;
      conclude();
   end
   initial
   begin
      rst = 1'b1;
      coreWrReady = 1'b1;
      repeat (2) @(negedge ref_clk);
      rst = 1'b0;
      @(negedge ref_clk);
      chk(bankOpen, 8'h00);
      for (int b = 0; b < 8; b++)
      begin
         cmd({3'h0, b[2:0], 4'b0010}, 10'h2a5 ^ {7'h0, b[2:0]});
         i_lpd_ctrl_model.nop(1);
         chk(bankOpen, (16'h1 << (b + 1)) - 1);
         if (b == 3)
            i_lpd_ctrl_model.nop(fawClk - 8);
      end
      $display("Test activate finished");
      wrt(3'h2, 9'h006, 32'h1000_0000);
      chk(wq.size(), 4);
      chk(beatDropped, 1'b0);
      drain("write", 1'b1);
      coreWrReady = 1'b0;
      wrt(3'h2, 9'h000, 32'h2000_0000);
      chk(beatDropped, 1'b1);
      coreWrReady = 1'b1;
      i_lpd_ctrl_model.tick(8);
      chk(wq.size() >= 2, 1'b1);
      drain("stalled write", 1'b1);
      for (int i = 0; i < 3; i++)
      begin
         mrw(8'h01, 8'h22 + i[7:0]);
         mrw(8'h02, 8'h01 + 8'(2 * i));
         rd(3'h1, 9'h00a + 9'(2 * i), 4 << i);
         i_lpd_ctrl_model.nop((2 << i) - 1);
         rd(3'h6, 9'h1f6, 4 << i);
         i_lpd_ctrl_model.nop(20);
         chk(rq.size(), 8 << i);
         drain("seamless read", 1'b0);
      end
      cmd(10'h30b, 10'h000);
      i_lpd_ctrl_model.nop(1);
      chk(bankOpen, 8'hbf);
      mrw(8'h3f, 8'ha5);
      chk(pulses, 1);
      chk(bankOpen, 8'h00);
      chk(accessError, 1'b0);
      $display("Test mode reset finished");
      cmd({3'h0, 3'h5, 4'b0010}, 10'h2a0);
      i_lpd_ctrl_model.nop(2);
      chk(bankOpen, 8'h20);
      rd(3'h5, 9'h004, 4);
      i_lpd_ctrl_model.nop(12);
      chk(rq.size(), 4);
      drain("reset defaults", 1'b0);
      cmd(10'h01b, 10'h000);
      i_lpd_ctrl_model.nop(tRpabClk);
      chk(bankOpen, 8'h00);
      chk(accessError, 1'b0);
      $display("Test precharge finished");
      conclude();
   end
endmodule
`default_nettype wire
